// ===== fapp_pkg.sv
// Package for the host-side controller of a 32K x 8 asynchronous parallel memory port.
// Assumes a single 125 MHz clock; all pin timing is derived from it here.
package fapp_pkg;
  localparam int ADDR_W         = 15;
  localparam int DATA_W         = 8;
  localparam int COL_W          = 3;
  localparam int ROW_LSB        = 3;
  localparam int CLK_PERIOD_NS  = 8;
  localparam int T_CE_ACCESS_NS = 70;
  localparam int T_PAGE_ACC_NS  = 40;
  localparam int T_OE_ACC_NS    = 25;
  localparam int T_HZ_NS        = 10;
  localparam int T_CA_NS        = 70;
  localparam int T_PC_NS        = 70;
  localparam int T_RC_NS        = 140;
  localparam int T_WP_NS        = 18;
  localparam int T_PWC_NS       = 35;
  localparam int T_WLC_NS       = 25;
  localparam int T_DS_NS        = 15;
  localparam int T_PU_US        = 250;
  // Least times round up to whole cycles.
  localparam int CYC_CE_ACC  = (T_CE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_PAGE    = (T_PAGE_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_OE      = (T_OE_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_HZ      = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_CA      = (T_CA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_PC      = (T_PC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_RC      = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_WP      = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_PWC     = (T_PWC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_WLC     = (T_WLC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_DS      = (T_DS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_PU      = (T_PU_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W       = 16;

  typedef struct packed {
    logic              write;
    logic              page;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fapp_req_s;

  typedef struct packed {
    logic              ce_n;
    logic              we_n;
    logic              oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe;
  } fapp_pins_s;
endpackage

// ===== fapp_timer.sv
// Down-counting delay timer; load sets the count, done is high once it reaches zero.
// Assumes load and en come from logic on the same clock.
`timescale 1ns/1ns
module fapp_timer #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = value;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
    end
  end

  assign done = (cnt_q == '0);
endmodule

// ===== fapp_sync.sv
// Three-stage synchroniser for a pin bus; out changes only when stages two and three agree.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ns
module fapp_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] din,
  output logic [W-1:0]      dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  always_comb begin
    out_d = out_q;
    if (s2_q == s3_q) begin
      out_d = s3_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else if (clk_en) begin
      s1_q  <= din;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule

// ===== fapp_host.sv
// Host controller that drives the asynchronous parallel port of a 32K x 8 memory.
// Assumes one 125 MHz clock; the memory pins are driven straight from flip-flops here.
`timescale 1ns/1ns
module fapp_host
  import fapp_pkg::*;
#(
  parameter int PU_CYCLES = fapp_pkg::CYC_PU
) (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic                       clk_en,
  input  wire fapp_pkg::fapp_req_s        req,
  input  wire logic                       req_valid,
  output logic                            req_ready,
  output logic [fapp_pkg::DATA_W-1:0]     rd_data,
  output logic                            rd_valid,
  output logic                            mem_ce_n,
  output logic                            mem_we_n,
  output logic                            mem_oe_n,
  output logic [fapp_pkg::ADDR_W-1:0]     mem_addr,
  output logic [fapp_pkg::DATA_W-1:0]     mem_dq_o,
  output logic                            mem_dq_oe,
  input  wire logic [fapp_pkg::DATA_W-1:0] mem_dq_i
);
  typedef enum logic [8:0] {
    ST_PWRUP  = 9'h001,
    ST_IDLE   = 9'h002,
    ST_RD     = 9'h004,
    ST_WR_SET = 9'h008,
    ST_WR_LO  = 9'h010,
    ST_WR_HI  = 9'h020,
    ST_ACT    = 9'h040,
    ST_PRECH  = 9'h080,
    ST_FLOAT  = 9'h100
  } fapp_state_e;

  fapp_state_e state_q;
  fapp_state_e state_d;
  fapp_pins_s  pins_q;
  fapp_pins_s  pins_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic              rvalid_q;
  logic              rvalid_d;
  logic              ready_q;
  logic              ready_d;
  logic [TMR_W-1:0]  ca_cnt_q;
  logic [TMR_W-1:0]  ca_cnt_d;
  logic [TMR_W-1:0]  cyc_cnt_q;
  logic [TMR_W-1:0]  cyc_cnt_d;
  logic [ADDR_W-1:ROW_LSB] row_q;
  logic [ADDR_W-1:ROW_LSB] row_d;
  logic [TMR_W-1:0]  row_cnt_q;
  logic [TMR_W-1:0]  row_cnt_d;
  logic [TMR_W-1:0]  tmr_val;
  logic              tmr_load;
  logic              tmr_done;
  logic [DATA_W-1:0] dq_sync;
  logic              pu_load_q;
  logic [TMR_W-1:0]  pu_cnt_q;
  logic [TMR_W-1:0]  pu_cnt_d;
  logic              pu_done;
  logic              accept;
  logic              same_row;

  fapp_timer #(.W(TMR_W)) u_tmr (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .load    (tmr_load),
    .value   (tmr_val),
    .done    (tmr_done)
  );

  fapp_sync #(.W(DATA_W)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .din     (mem_dq_i),
    .dout    (dq_sync)
  );

  // Power-up wait counted separately, in a counter as wide (TMR_W) as the shared timer.
  always_comb begin
    pu_cnt_d = pu_cnt_q;
    if (pu_load_q) begin
      pu_cnt_d = TMR_W'(PU_CYCLES);
    end else if (pu_cnt_q != '0) begin
      pu_cnt_d = pu_cnt_q - TMR_W'(1);
    end
  end
  assign pu_done = !pu_load_q && (pu_cnt_q == '0);

  assign same_row = (req.addr[ADDR_W-1:ROW_LSB] == row_q);
  assign accept   = req_valid && ready_q;

  always_comb begin
    state_d   = state_q;
    pins_d    = pins_q;
    rdata_d   = rdata_q;
    rvalid_d  = 1'b0;
    ready_d   = 1'b0;
    tmr_load  = 1'b0;
    tmr_val   = '0;
    row_d     = row_q;
    ca_cnt_d  = (ca_cnt_q != '0) ? ca_cnt_q - TMR_W'(1) : ca_cnt_q;
    cyc_cnt_d = (cyc_cnt_q != '0) ? cyc_cnt_q - TMR_W'(1) : cyc_cnt_q;
    row_cnt_d = (row_cnt_q != '0) ? row_cnt_q - TMR_W'(1) : row_cnt_q;
    case (state_q)
      ST_PWRUP: begin
        if (pu_done) begin
          state_d = ST_IDLE;
          ready_d = 1'b1;
        end
      end
      ST_IDLE, ST_ACT: begin
        ready_d = 1'b1;
        if (accept) begin
          ready_d = 1'b0;
          // Page access keeps select low only when the row is unchanged.
          if (state_q == ST_ACT && !(req.page && same_row)) begin
            state_d        = ST_PRECH;
            pins_d.ce_n    = 1'b1;
            pins_d.oe_n    = 1'b1;
            tmr_load       = 1'b1;
            tmr_val        = TMR_W'(CYC_PC);
            ready_d        = 1'b0;
          end else begin
            if (state_q == ST_IDLE) begin
              ca_cnt_d  = TMR_W'(CYC_CA);
              cyc_cnt_d = TMR_W'(CYC_RC);
              row_cnt_d = TMR_W'(CYC_RC);
              row_d     = req.addr[ADDR_W-1:ROW_LSB];
            end
            pins_d.ce_n = 1'b0;
            pins_d.addr = req.addr;
            tmr_load    = 1'b1;
            if (req.write) begin
              // Strobe falls after select, giving a strobe-controlled write.
              pins_d.oe_n   = 1'b1;
              pins_d.dq_out = req.wdata;
              state_d       = ST_WR_SET;
              tmr_val     = TMR_W'(CYC_DS);
            end else begin
              pins_d.oe_n = 1'b0;
              state_d     = ST_RD;
              tmr_val     = (state_q == ST_ACT) ? TMR_W'(CYC_PAGE + 1)
                                                : TMR_W'(CYC_CE_ACC + 1);
            end
          end
        end else if (state_q == ST_ACT && ca_cnt_q == '0) begin
          // Idle select is released so the memory can pre-charge.
          state_d     = ST_PRECH;
          pins_d.ce_n = 1'b1;
          pins_d.oe_n = 1'b1;
          tmr_load    = 1'b1;
          tmr_val     = TMR_W'(CYC_PC);
          ready_d     = 1'b0;
        end
      end
      ST_RD: begin
        // Extra cycles cover the three-stage input synchroniser.
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_val  = TMR_W'(3);
          state_d  = ST_FLOAT;
        end
      end
      ST_FLOAT: begin
        if (tmr_done) begin
          rdata_d  = dq_sync;
          rvalid_d = 1'b1;
          state_d  = ST_ACT;
          ready_d  = 1'b1;
        end
      end
      ST_WR_SET: begin
        if (tmr_done) begin
          pins_d.we_n  = 1'b0;
          tmr_load     = 1'b1;
          tmr_val      = TMR_W'(CYC_HZ);
          state_d      = ST_WR_LO;
        end
      end
      ST_WR_LO: begin
        if (tmr_done && !pins_q.dq_oe) begin
          pins_d.dq_oe  = 1'b1;
          tmr_load      = 1'b1;
          tmr_val       = TMR_W'(CYC_WP + CYC_DS);
        end else if (tmr_done && ca_cnt_q == '0 && row_cnt_q == '0) begin
          // Data is latched on this strobe rise, before select ever rises.
          pins_d.we_n = 1'b1;
          tmr_load    = 1'b1;
          tmr_val     = TMR_W'(CYC_PWC - CYC_WP);
          state_d     = ST_WR_HI;
        end
      end
      ST_WR_HI: begin
        // Zero data hold: release data the cycle after the strobe rises.
        pins_d.dq_oe = 1'b0;
        if (tmr_done) begin
          state_d = ST_ACT;
          ready_d = 1'b1;
        end
      end
      ST_PRECH: begin
        if (tmr_done && cyc_cnt_q == '0) begin
          state_d = ST_IDLE;
          ready_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_PWRUP;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q       <= ST_PWRUP;
      pins_q.ce_n   <= 1'b1;
      pins_q.we_n   <= 1'b1;
      pins_q.oe_n   <= 1'b1;
      pins_q.addr   <= '0;
      pins_q.dq_out <= '0;
      pins_q.dq_oe  <= 1'b0;
      rdata_q       <= '0;
      rvalid_q      <= 1'b0;
      ready_q       <= 1'b0;
      ca_cnt_q      <= '0;
      cyc_cnt_q     <= '0;
      row_q         <= '0;
      row_cnt_q     <= '0;
      pu_load_q     <= 1'b1;
      pu_cnt_q      <= '0;
    end else if (clk_en) begin
      state_q   <= state_d;
      pins_q    <= pins_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
      ready_q   <= ready_d;
      ca_cnt_q  <= ca_cnt_d;
      cyc_cnt_q <= cyc_cnt_d;
      row_q     <= row_d;
      row_cnt_q <= row_cnt_d;
      pu_load_q <= 1'b0;
      pu_cnt_q  <= pu_cnt_d;
    end
  end

  assign req_ready = ready_q;
  assign rd_data   = rdata_q;
  assign rd_valid  = rvalid_q;
  assign mem_ce_n  = pins_q.ce_n;
  assign mem_we_n  = pins_q.we_n;
  assign mem_oe_n  = pins_q.oe_n;
  assign mem_addr  = pins_q.addr;
  assign mem_dq_o  = pins_q.dq_out;
  assign mem_dq_oe = pins_q.dq_oe;
endmodule

// ===== fapp_host_monitor.sv
// Checker for the host-side pin timing of the asynchronous parallel memory port.
// Assumes it is bound into fapp_host and that clk_en stays high while it watches.
`timescale 1ns/1ns
module fapp_host_monitor
  import fapp_pkg::*;
#(
  parameter int PU_CYCLES = fapp_pkg::CYC_PU
) (
  input wire logic                        clk,
  input wire logic                        sys_rst,
  input wire logic                        mem_ce_n,
  input wire logic                        mem_we_n,
  input wire logic [fapp_pkg::ADDR_W-1:0] mem_addr
);
  logic [7:0]  ce_lo_q, ce_lo_d, cyc_q, cyc_d, row_q, row_d;
  logic [11:0] rowp_q, rowp_d;
  logic [15:0] pu_q, pu_d;
  logic        ce_prev_q;

  // Counters saturate so that long idle stretches never wrap into a false short gap.
  always_comb begin
    ce_lo_d = mem_ce_n ? 8'h00 : ce_lo_q + {7'h00, ce_lo_q != 8'hFF};
    cyc_d   = (ce_prev_q && !mem_ce_n) ? 8'h01 : cyc_q + {7'h00, cyc_q != 8'hFF};
    rowp_d  = mem_addr[ADDR_W-1:ROW_LSB];
    row_d   = (rowp_d != rowp_q) ? 8'h01 : row_q + {7'h00, row_q != 8'hFF};
    pu_d    = pu_q + {15'h0000, pu_q != 16'hFFFF};
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ce_lo_q   <= 8'h00;
      cyc_q     <= 8'hFF;
      row_q     <= 8'hFF;
      rowp_q    <= 12'h000;
      pu_q      <= 16'h0000;
      ce_prev_q <= 1'b1;
    end else begin
      ce_lo_q   <= ce_lo_d;
      cyc_q     <= cyc_d;
      row_q     <= row_d;
      rowp_q    <= rowp_d;
      pu_q      <= pu_d;
      ce_prev_q <= mem_ce_n;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_ce_held;
    !mem_ce_n [*8];
  endsequence
  sequence s_we_held;
    !mem_we_n [*2];
  endsequence

  chk_ce_low_time: assert property ($fell(mem_ce_n) |=> s_ce_held)
    else $error("select low for too short a time");
  chk_ce_high_time: assert property ($rose(mem_ce_n) |=> mem_ce_n [*8])
    else $error("select high for too short a time");
  chk_cycle_time: assert property ($fell(mem_ce_n) |-> cyc_q >= 18)
    else $error("access cycle shorter than allowed");
  chk_addr_hold: assert property ($fell(mem_ce_n) |=> $stable(mem_addr) [*8])
    else $error("address changed too soon after select fell");
  chk_write_type: assert property ($fell(mem_ce_n) |-> mem_we_n)
    else $error("strobe low while select fell");
  chk_we_after_ce: assert property ($rose(mem_we_n) |-> !mem_ce_n && ce_lo_q >= 9)
    else $error("strobe raised too soon after select fell");
  chk_we_pulse: assert property ($fell(mem_we_n) |=> s_we_held)
    else $error("strobe pulse too short");
  chk_page_spacing: assert property ($fell(mem_we_n) |=> !$fell(mem_we_n) [*4])
    else $error("strobe cycles too close");
  chk_we_to_deselect: assert property ($fell(mem_we_n) |=> s_we_held ##0 !mem_ce_n ##1 !mem_ce_n)
    else $error("select released too soon after strobe fell");
  chk_row_to_strobe: assert property ($rose(mem_we_n) |-> row_q >= 18)
    else $error("strobe raised too soon after row change");
  chk_col_stable: assert property (!mem_ce_n && $changed(mem_addr[COL_W-1:0]) |=> $stable(mem_addr[COL_W-1:0]))
    else $error("column address held too briefly");
  chk_power_wait: assert property (!mem_ce_n |-> pu_q >= PU_CYCLES)
    else $error("access before power-up wait ended");
endmodule

bind fapp_host fapp_host_monitor #(.PU_CYCLES(PU_CYCLES)) i_mon (
  .clk      (clk),
  .sys_rst  (sys_rst),
  .mem_ce_n (mem_ce_n),
  .mem_we_n (mem_we_n),
  .mem_addr (mem_addr)
);

// ===== fapp_mem_model.sv
// Behavioural model of the 32K x 8 memory behind the host controller's pins.
// Assumes the bench resolves the shared data wire and feeds it to dq_in.
`timescale 1ns/1ns
module fapp_mem_model
  import fapp_pkg::*;
(
  input  wire logic [0:0]                  ce_n,
  input  wire logic                        we_n,
  input  wire logic                        oe_n,
  input  wire logic [fapp_pkg::ADDR_W-1:0] addr,
  input  wire logic [fapp_pkg::DATA_W-1:0] dq_in,
  output logic [fapp_pkg::DATA_W-1:0]      dq_out,
  output logic                             dq_oe
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] last;
  logic [ADDR_W-1:0] pa;
  logic              pce, pwe, poe;
  longint            t_ce, t_col, t_row, t_oe, t_we, now;

  // A 1 ns poll keeps every timing figure at its worst bound; data shows garbage until valid.
  initial begin
    dq_oe = 1'b0;
    dq_out = 8'h00;
    last = 8'h00;
    {pce, pwe, poe} = 3'h7;
    pa = '0;
    {t_ce, t_col, t_row, t_oe, t_we} = '0;
    forever begin
      #1;
      now = $time;
      if (pce && !ce_n) t_ce = now;
      else if (!ce_n && addr[ADDR_W-1:ROW_LSB] != pa[ADDR_W-1:ROW_LSB]) t_row = now;
      if (!ce_n && addr[COL_W-1:0] != pa[COL_W-1:0]) t_col = now;
      if (poe && !oe_n) t_oe = now;
      if (!pwe && we_n) t_we = now;
      if ((!pwe && we_n && !ce_n) || (!pce && ce_n && !pwe)) mem[pa] = dq_in;
      if (ce_n || oe_n || !we_n) begin
        dq_oe = 1'b0;
      end else begin
        dq_oe = (now >= t_we + 5);
        if (now >= t_ce + 70 && now >= t_col + 40 && now >= t_row + 140 && now >= t_oe + 25)
          last = mem[addr];
        else if (now >= t_col + 3)
          last = ~last;
        dq_out = last;
      end
      pce = ce_n;
      pwe = we_n;
      poe = oe_n;
      pa = addr;
    end
  end
endmodule

// ===== test_fram_async_parallel_port.sv
// Self-checking bench for the host controller of the asynchronous parallel memory port.
// Assumes the memory model and the checker are compiled before this top module.
`timescale 1ns/1ns
module test_fram_async_parallel_port;
  import fapp_pkg::*;
  localparam int PU = 20;
  logic              clk, sys_rst, req_valid, req_ready, rd_valid;
  logic              mem_ce_n, mem_we_n, mem_oe_n, mem_dq_oe, dev_oe;
  fapp_req_s         req;
  logic [DATA_W-1:0] rd_data, mem_dq_o, dev_dq, dq_w;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] shadow [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] exp_q [$];
  logic [11:0]       rows [4];
  logic [11:0]       cur_row;
  logic [31:0]       rng;
  int                err_total, compares;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  fapp_host #(.PU_CYCLES(PU)) i_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .req(req), .req_valid(req_valid), .req_ready(req_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .mem_ce_n(mem_ce_n), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n),
    .mem_addr(mem_addr), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe), .mem_dq_i(dq_w));
  fapp_mem_model i_mem (.ce_n(mem_ce_n), .we_n(mem_we_n), .oe_n(mem_oe_n), .addr(mem_addr),
    .dq_in(dq_w), .dq_out(dev_dq), .dq_oe(dev_oe));

  // An undriven wire flips every cycle so a stale value can never pass for read data.
  always @(posedge clk or mem_dq_oe or mem_dq_o or dev_oe or dev_dq) begin
    if (mem_dq_oe === 1'b1) dq_w = mem_dq_o;
    else if (dev_oe === 1'b1) dq_w = dev_dq;
    else dq_w = ~dq_w;
  end

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", name, e, g);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 3000);
    if (req_ready !== 1'b1) begin
      check("req_ready", 1, req_ready);
      end_of_test();
    end
  endtask

  task automatic do_req(input logic w, input logic p, input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] d;
    logic              held;
    d = DATA_W'(rnd());
    @(posedge clk);
    req <= '{write: w, page: p, addr: a, wdata: d};
    req_valid <= 1'b1;
    // A take while select is held for another row only starts a pre-charge.
    do begin
      wait_ready();
      held = (mem_ce_n === 1'b0) && !(p && a[ADDR_W-1:ROW_LSB] === cur_row);
    end while (held);
    req_valid <= 1'b0;
    cur_row = a[ADDR_W-1:ROW_LSB];
    if (w) begin
      shadow[a] = d;
    end else begin
      exp_q.push_back(shadow[a]);
    end
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    check("reads outstanding", 0, exp_q.size());
    // The last write must finish before anything may cut it.
    wait_ready();
  endtask

  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected rd_valid", 0, 1);
      else check("rd_data", {24'h0, exp_q.pop_front()}, {24'h0, rd_data});
    end
  end

  initial begin
    int n;
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    rng = 32'd31;
    err_total = 0;
    compares = 0;
    dq_w = 8'h3C;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    n = 0;
    while (req_ready !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    check("power-up wait", 1, 32'(n >= PU));
    for (int r = 0; r < 4; r++) begin
      rows[r] = 12'(rnd());
      n = int'(rnd() % 8);
      for (int k = 0; k < 8; k++) do_req(1'b1, 1'b1, {rows[r], 3'(k * 5 + n)});
    end
    for (int r = 0; r < 4; r++)
      for (int k = 0; k < 8; k++) do_req(1'b0, 1'b1, {rows[r], 3'(k * 3 + r)});
    for (int k = 0; k < 40; k++) begin
      n = int'(rnd());
      do_req(n[0], n[1], {rows[n[3:2]], n[6:4]});
    end
    drain();
    // A read cut off by reset must not reach the data port or the check queue.
    @(posedge clk);
    req <= '{write: 1'b0, page: 1'b0, addr: {rows[0], 3'h2}, wdata: 8'h00};
    req_valid <= 1'b1;
    wait_ready();
    repeat (4) @(posedge clk);
    sys_rst <= 1'b1;
    req_valid <= 1'b0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    exp_q.delete();
    for (int k = 0; k < 8; k++) do_req(1'b0, 1'b1, {rows[0], 3'(7 - k)});
    drain();
    end_of_test();
  end
endmodule
